// File: src/swd_pkg.sv
// Constants shared by the supervisory watchdog and its oscillator tick source
package swd_pkg;
  localparam int CLK_MHZ = 125;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 32;
  localparam int RC_DIV = 1;
  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_MODE = 8'h0f;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h3c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h40;
  // Mode register fields
  localparam int MODE_W = 4;
  localparam int BIT_HALT_RUN = 2;
  localparam int BIT_STOP_RUN = 3;
  localparam logic [MODE_W-1:0] MODE_RESET = 4'hd;
  localparam logic [1:0] TAP_5MS = 2'h0;
  localparam logic [1:0] TAP_10MS = 2'h1;
  localparam logic [1:0] TAP_20MS = 2'h2;
  localparam logic [1:0] TAP_80MS = 2'h3;
  // Status register fields
  localparam int ST_BIT_RUN = 0;
  localparam int ST_BIT_WIN = 1;
  localparam int ST_BIT_WDRST = 2;
  localparam int ST_BIT_TAP = 4;
  // Times, microseconds, and derived counts in oscillator ticks
  localparam longint TAP0_US = 5000;
  localparam longint TAP1_US = 10000;
  localparam longint TAP2_US = 20000;
  localparam longint TAP3_US = 80000;
  localparam longint POR_MIN_US = 2500;
  localparam longint POR_MAX_US = 10000;
  localparam int TAP0_TICKS = int'((TAP0_US * CLK_MHZ + RC_DIV - 1) / RC_DIV);
  localparam int TAP1_TICKS = int'((TAP1_US * CLK_MHZ + RC_DIV - 1) / RC_DIV);
  localparam int TAP2_TICKS = int'((TAP2_US * CLK_MHZ + RC_DIV - 1) / RC_DIV);
  localparam int TAP3_TICKS = int'((TAP3_US * CLK_MHZ + RC_DIV - 1) / RC_DIV);
  localparam int POR_TICKS = int'((POR_MIN_US * CLK_MHZ + RC_DIV - 1) / RC_DIV);
  // Write window after the first instruction, in clock cycles
  localparam int WIN_CYCLES = 120;
  localparam int WDRST_CYCLES = 16;
  // Condition flags left by the refresh instruction: Z, S, V
  localparam logic [2:0] FLAGS_AFTER_REFRESH = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SWD_POR = 2'b00,
    SWD_IDLE = 2'b01,
    SWD_RUN = 2'b10,
    SWD_WDRST = 2'b11
  } swd_state_e;
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_MODE = 2'b01,
    SEL_STATUS = 2'b10
  } swd_sel_e;
endpackage

// File: src/swd_rc_osc.sv
// Free-running oscillator tick source, never gated by halt or stop
`timescale 1ns/1ns
`default_nettype none
module swd_rc_osc #(
  parameter int DIV = 1
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  logic [15:0] div_ff;

  // Runs apart from core clock gating so timeouts still elapse
  always_ff @(posedge clk) begin
    if (rst) begin
      div_ff <= 16'h0;
      tick <= 1'b0;
    end else if (div_ff == 16'(DIV - 1)) begin
      div_ff <= 16'h0;
      tick <= 1'b1;
    end else begin
      div_ff <= div_ff + 16'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: src/swd_top.sv
// Supervisory watchdog with power-on delay and locked mode register over AXI4-Lite
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Unrefreshed counter reaching terminal count resets the core.
// - Watchdog idle after reset until first refresh instruction starts it.
// - Each later refresh instruction restarts the timeout period.
// - Counter advances only on ticks of the free-running oscillator.
// - Refresh instruction also updates zero, sign and overflow flags.
// - Mode bits 1:0 pick timeout of 5, 10, 20 or 80 ms.
// - Mode bit 2 set lets counting continue during halt.
// - Mode bit 3 set lets counting continue during stop.
// - Mode bits 7:4 are reserved and ignored.
// - Mode register writable only 120 clocks after first instruction.
// - Mode register is write-only; reads return zero.
// - Power-on reset delay also counted on oscillator ticks.
module swd_top
  import swd_pkg::*;
#(
  parameter int TAP0_LIM = swd_pkg::TAP0_TICKS,
  parameter int TAP1_LIM = swd_pkg::TAP1_TICKS,
  parameter int TAP2_LIM = swd_pkg::TAP2_TICKS,
  parameter int TAP3_LIM = swd_pkg::TAP3_TICKS,
  parameter int POR_LIM = swd_pkg::POR_TICKS
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic WATCHDOG_REFRESH_INSTRUCTION,
  input wire logic INSTR_EXEC,
  input wire logic HALT_MODE,
  input wire logic STOP_MODE,
  input wire logic STOP_RECOVER,
  output logic CORE_RST,
  output logic FLAG_WE,
  output logic [2:0] FLAG_ZSV,
  input wire logic [swd_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [swd_pkg::DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [swd_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [swd_pkg::DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import swd_pkg::*;

  function automatic swd_sel_e reg_sel(input logic [ADDR_W-1:0] a);
    if (a == ADDR_MODE) begin
      reg_sel = SEL_MODE;
    end else if (a == ADDR_STATUS) begin
      reg_sel = SEL_STATUS;
    end else begin
      reg_sel = SEL_NONE;
    end
  endfunction

  function automatic logic [CNT_W-1:0] tap_limit(input logic [1:0] tap);
    case (tap)
      TAP_5MS: tap_limit = CNT_W'(TAP0_LIM);
      TAP_10MS: tap_limit = CNT_W'(TAP1_LIM);
      TAP_20MS: tap_limit = CNT_W'(TAP2_LIM);
      default: tap_limit = CNT_W'(TAP3_LIM);
    endcase
  endfunction

  logic rc_tick;
  swd_state_e state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] lim_ff;
  logic [MODE_W-1:0] mode_ff;
  logic [7:0] wdrst_cnt_ff;
  logic win_arm_ff;
  logic win_open_ff;
  logic [7:0] win_cnt_ff;
  logic wdrst_seen_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic commit;
  logic mode_wr;
  logic refresh;
  logic paused;
  logic terminal;

  swd_rc_osc #(.DIV(RC_DIV)) u_osc (
    .clk(SYS_CLK),
    .rst(RST),
    .tick(rc_tick)
  );

  assign refresh = WATCHDOG_REFRESH_INSTRUCTION && (state_ff == SWD_IDLE || state_ff == SWD_RUN);
  assign paused = (HALT_MODE && !mode_ff[BIT_HALT_RUN]) || (STOP_MODE && !mode_ff[BIT_STOP_RUN]);
  assign terminal = rc_tick && (cnt_ff == lim_ff - CNT_W'(1));
  assign commit = aw_got_ff && w_got_ff && !S_AXI_BVALID;
  assign mode_wr = commit && reg_sel(awaddr_ff) == SEL_MODE && wstrb_ff[0] && win_open_ff;

  // Core supervision state
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_ff <= SWD_POR;
      cnt_ff <= '0;
      lim_ff <= '0;
      wdrst_cnt_ff <= 8'h0;
      CORE_RST <= 1'b1;
      wdrst_seen_ff <= 1'b0;
    end else begin
      case (state_ff)
        SWD_POR: begin
          if (rc_tick) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
          end
          if (terminal || (rc_tick && cnt_ff >= CNT_W'(POR_LIM - 1))) begin
            state_ff <= SWD_IDLE;
            cnt_ff <= '0;
            CORE_RST <= 1'b0;
          end
          lim_ff <= CNT_W'(POR_LIM);
        end
        SWD_IDLE: begin
          if (refresh) begin
            state_ff <= SWD_RUN;
            cnt_ff <= '0;
            lim_ff <= tap_limit(mode_ff[1:0]);
          end
        end
        SWD_RUN: begin
          if (refresh) begin
            cnt_ff <= '0;
            lim_ff <= tap_limit(mode_ff[1:0]);
          end else if (rc_tick && !paused) begin
            if (terminal) begin
              state_ff <= SWD_WDRST;
              CORE_RST <= 1'b1;
              wdrst_seen_ff <= 1'b1;
              cnt_ff <= '0;
              wdrst_cnt_ff <= 8'h0;
            end else begin
              cnt_ff <= cnt_ff + CNT_W'(1);
            end
          end
        end
        default: begin
          wdrst_cnt_ff <= wdrst_cnt_ff + 8'h1;
          if (wdrst_cnt_ff == 8'(WDRST_CYCLES - 1)) begin
            state_ff <= SWD_IDLE;
            CORE_RST <= 1'b0;
          end
        end
      endcase
    end
  end

  // Condition flag update from the refresh instruction
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      FLAG_WE <= 1'b0;
      FLAG_ZSV <= 3'h0;
    end else begin
      FLAG_WE <= refresh;
      FLAG_ZSV <= FLAGS_AFTER_REFRESH;
    end
  end

  // Write window: opens at first instruction after any reset or recovery
  always_ff @(posedge SYS_CLK) begin
    if (RST || CORE_RST || STOP_RECOVER) begin
      win_arm_ff <= 1'b1;
      win_open_ff <= 1'b0;
      win_cnt_ff <= 8'h0;
    end else if (win_arm_ff && INSTR_EXEC) begin
      win_arm_ff <= 1'b0;
      win_open_ff <= 1'b1;
      win_cnt_ff <= 8'h0;
    end else if (win_open_ff) begin
      win_cnt_ff <= win_cnt_ff + 8'h1;
      if (win_cnt_ff == 8'(WIN_CYCLES - 1)) begin
        win_open_ff <= 1'b0;
      end
    end
  end

  // Mode register keeps its contents across watchdog reset and recovery
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      mode_ff <= MODE_RESET;
    end else if (mode_wr) begin
      mode_ff <= wdata_ff[MODE_W-1:0];
    end
  end

  // AXI4-Lite write channels, address and data taken in either order
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_ff <= 1'b1;
        wdata_ff <= S_AXI_WDATA;
        wstrb_ff <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (commit) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        // Locked writes are dropped quietly, as software cannot tell
        S_AXI_BRESP <= (reg_sel(awaddr_ff) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= RESP_OKAY;
      S_AXI_RDATA <= '0;
      if (reg_sel(S_AXI_ARADDR) == SEL_STATUS) begin
        S_AXI_RDATA[ST_BIT_RUN] <= (state_ff == SWD_RUN);
        S_AXI_RDATA[ST_BIT_WIN] <= win_open_ff;
        S_AXI_RDATA[ST_BIT_WDRST] <= wdrst_seen_ff;
        S_AXI_RDATA[ST_BIT_TAP +: 2] <= mode_ff[1:0];
      end else if (reg_sel(S_AXI_ARADDR) == SEL_NONE) begin
        S_AXI_RRESP <= RESP_SLVERR;
      end
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  property p_terminal_resets;
    @(posedge SYS_CLK) disable iff (RST)
    state_ff == SWD_RUN && !refresh && rc_tick && !paused && terminal |=> CORE_RST ##1 CORE_RST;
  endproperty
  a_terminal_resets: assert property (p_terminal_resets) else $error("no core reset at terminal count");

  property p_start;
    @(posedge SYS_CLK) disable iff (RST)
    state_ff == SWD_IDLE && WATCHDOG_REFRESH_INSTRUCTION |=> state_ff == SWD_RUN && cnt_ff == '0;
  endproperty
  a_start: assert property (p_start) else $error("refresh did not start watchdog");

  property p_idle_still;
    @(posedge SYS_CLK) disable iff (RST)
    state_ff == SWD_IDLE && !WATCHDOG_REFRESH_INSTRUCTION |=> state_ff == SWD_IDLE && !CORE_RST;
  endproperty
  a_idle_still: assert property (p_idle_still) else $error("idle watchdog acted");

  property p_restart;
    @(posedge SYS_CLK) disable iff (RST)
    state_ff == SWD_RUN && WATCHDOG_REFRESH_INSTRUCTION |=> cnt_ff == '0 && !CORE_RST;
  endproperty
  a_restart: assert property (p_restart) else $error("refresh did not restart count");

  property p_tick_only;
    @(posedge SYS_CLK) disable iff (RST)
    state_ff == SWD_RUN && !WATCHDOG_REFRESH_INSTRUCTION && !paused |=>
      CORE_RST || cnt_ff == $past(cnt_ff) + CNT_W'($past(rc_tick));
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("count moved without oscillator tick");

  property p_flags;
    @(posedge SYS_CLK) disable iff (RST)
    refresh |=> FLAG_WE && FLAG_ZSV == FLAGS_AFTER_REFRESH ##1 !FLAG_WE || $past(refresh);
  endproperty
  a_flags: assert property (p_flags) else $error("flags not updated by refresh");

  property p_tap;
    @(posedge SYS_CLK) disable iff (RST)
    refresh |=> lim_ff == tap_limit($past(mode_ff[1:0]));
  endproperty
  a_tap: assert property (p_tap) else $error("wrong timeout tap");

  property p_halt_hold;
    @(posedge SYS_CLK) disable iff (RST)
    state_ff == SWD_RUN && HALT_MODE && !mode_ff[BIT_HALT_RUN] && !WATCHDOG_REFRESH_INSTRUCTION |=> $stable(cnt_ff);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("counted during halt");

  property p_stop_hold;
    @(posedge SYS_CLK) disable iff (RST)
    state_ff == SWD_RUN && STOP_MODE && !mode_ff[BIT_STOP_RUN] && !WATCHDOG_REFRESH_INSTRUCTION |=> $stable(cnt_ff);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("counted during stop");

  property p_locked;
    @(posedge SYS_CLK) disable iff (RST)
    !win_open_ff |=> $stable(mode_ff);
  endproperty
  a_locked: assert property (p_locked) else $error("mode changed outside window");

  property p_write_only;
    @(posedge SYS_CLK) disable iff (RST)
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == ADDR_MODE |=> S_AXI_RVALID && S_AXI_RDATA == '0;
  endproperty
  a_write_only: assert property (p_write_only) else $error("mode register readable");

  property p_por;
    @(posedge SYS_CLK) disable iff (RST)
    state_ff == SWD_POR |-> CORE_RST && cnt_ff < CNT_W'(POR_LIM);
  endproperty
  a_por: assert property (p_por) else $error("core released during power-on delay");

  property p_tap_held;
    @(posedge SYS_CLK) disable iff (RST)
    state_ff == SWD_RUN && !WATCHDOG_REFRESH_INSTRUCTION ##1 state_ff == SWD_RUN |-> $stable(lim_ff);
  endproperty
  a_tap_held: assert property (p_tap_held) else $error("running timeout changed");

  c_refresh: cover property (@(posedge SYS_CLK) disable iff (RST) state_ff == SWD_RUN && refresh);
  c_fire: cover property (@(posedge SYS_CLK) disable iff (RST) state_ff == SWD_RUN ##1 state_ff == SWD_WDRST);
  c_mode_wr: cover property (@(posedge SYS_CLK) disable iff (RST) mode_wr);
endmodule
`default_nettype wire

// File: verif/swd_core_model.sv
// Core model: runs instructions out of reset, refreshes on request or period
`timescale 1ns/1ns
`default_nettype none
module swd_core_model (
  input wire logic clk,
  input wire logic core_rst,
  input wire logic kick,
  input wire logic [7:0] period,
  output logic watchdog_refresh_instruction,
  output logic instr_exec
);
  logic [7:0] cnt_ff;
  logic due;
  initial begin
    cnt_ff = 8'h0;
    watchdog_refresh_instruction = 1'b0;
    instr_exec = 1'b0;
  end
  assign due = period != 8'h0 && cnt_ff + 8'h1 >= period;
  // A core held in reset executes nothing
  always @(posedge clk) begin
    instr_exec <= !core_rst;
    cnt_ff <= (core_rst || due) ? 8'h0 : cnt_ff + 8'h1;
    watchdog_refresh_instruction <= !core_rst && (kick || due);
  end
endmodule
`default_nettype wire

// File: verif/tb_supervisory_watchdog.sv
// Self-checking bench for the supervisory watchdog
`timescale 1ns/1ns
`default_nettype none
module tb_supervisory_watchdog;
  import swd_pkg::*;
  localparam int L0 = 20, L1 = 30, L2 = 40, L3 = 50, LP = 10;
  logic clk, rst, halt, stop, recov, kick, core_rst, flag_we, refresh_ins, ins;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [2:0] zsv;
  logic [7:0] period, awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic refresh_q = 1'b0;
  int num_errors = 0, num_checks = 0, cyc = 0, n;
  integer seed = 32'hd9504412;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  swd_core_model core_u (.clk(clk), .core_rst(core_rst), .kick(kick), .period(period),
    .watchdog_refresh_instruction(refresh_ins), .instr_exec(ins));
  swd_top #(.TAP0_LIM(L0), .TAP1_LIM(L1), .TAP2_LIM(L2), .TAP3_LIM(L3), .POR_LIM(LP)) dut_u (
    .SYS_CLK(clk), .RST(rst), .WATCHDOG_REFRESH_INSTRUCTION(refresh_ins), .INSTR_EXEC(ins), .HALT_MODE(halt),
    .STOP_MODE(stop), .STOP_RECOVER(recov), .CORE_RST(core_rst), .FLAG_WE(flag_we),
    .FLAG_ZSV(zsv), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  function automatic int lim(input int t);
    return t == 0 ? L0 : t == 1 ? L1 : t == 2 ? L2 : L3;
  endfunction
  task automatic chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid)
      @(posedge clk);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge clk);
    while (!arready);
    arvalid <= 1'b0;
    while (!rvalid)
      @(posedge clk);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // Counts edges while the core reset sits at lvl
  task automatic wait_lvl(input logic lvl, output int k);
    k = 0;
    while (core_rst === lvl && k < 500) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic pulse;
    @(posedge clk);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    refresh_q <= refresh_ins && !core_rst;
    if (!rst && (refresh_q || flag_we !== 1'b0))
      chk(flag_we === refresh_q && zsv === FLAGS_AFTER_REFRESH, "refresh flags");
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    rst = 1'b1;
    {halt, stop, recov, kick, awvalid, wvalid, bready, arvalid, rready} = '0;
    {period, awaddr, araddr} = '0;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (10) @(posedge clk);
    chk(core_rst === 1'b1, "reset held");
    rst <= 1'b0;
    wait_lvl(1'b1, n);
    chk(n >= LP - 1 && n <= LP + 4, "power-on delay");
    axw(8'h80, 32'h0, r);
    chk(r === RESP_SLVERR, "unmapped write");
    axr(ADDR_MODE, d, r);
    chk(d === 32'h0 && r === RESP_OKAY, "mode read");
    $display("test reset done");
    for (int t = 0; t < 4; t++) begin
      wait_lvl(1'b1, n);
      d = $random(seed);
      axw(ADDR_MODE, {d[31:4], 2'b11, 2'(t)}, r);
      axr(ADDR_STATUS, d, r);
      chk(d[5:4] === 2'(t) && d[1] === 1'b1, "tap stored");
      if (t == 0) begin
        repeat (150) @(posedge clk);
        chk(core_rst === 1'b0, "idle after reset");
        axw(ADDR_MODE, 32'h3, r);
        chk(r === RESP_OKAY, "locked write answered");
        axr(ADDR_STATUS, d, r);
        chk(d[5:4] === 2'h0 && d[1:0] === 2'h0, "mode locked");
      end
      pulse();
      // Last tap also runs through stop, as bit 3 is set
      stop <= (t == 3);
      wait_lvl(1'b0, n);
      stop <= 1'b0;
      chk(n >= lim(t) + 1 && n <= lim(t) + 4, "timeout");
      wait_lvl(1'b1, n);
      chk(n == WDRST_CYCLES, "reset length");
    end
    $display("test taps done");
    axw(ADDR_MODE, 32'h0, r);
    period <= 8'(5 + {$random(seed)} % 10);
    repeat (200) @(posedge clk);
    axr(ADDR_STATUS, d, r);
    chk(core_rst === 1'b0 && d[2:0] === 3'b101, "refresh keeps running");
    period <= 8'h0;
    halt <= 1'b1;
    repeat (100) @(posedge clk);
    chk(core_rst === 1'b0, "paused in halt");
    halt <= 1'b0;
    wait_lvl(1'b0, n);
    chk(n >= 4 && n <= L0 + 4, "resume after halt");
    wait_lvl(1'b1, n);
    axw(ADDR_MODE, 32'h4, r);
    pulse();
    halt <= 1'b1;
    wait_lvl(1'b0, n);
    chk(n >= L0 + 1 && n <= L0 + 4, "count during halt");
    halt <= 1'b0;
    wait_lvl(1'b1, n);
    pulse();
    stop <= 1'b1;
    repeat (150) @(posedge clk);
    chk(core_rst === 1'b0, "paused in stop");
    recov <= 1'b1;
    @(posedge clk);
    recov <= 1'b0;
    // Written while still paused so the running count cannot expire first
    axw(ADDR_MODE, 32'h6, r);
    axr(ADDR_STATUS, d, r);
    chk(d[5:4] === 2'h2, "window after recovery");
    stop <= 1'b0;
    pulse();
    wait_lvl(1'b0, n);
    chk(n >= L2 + 1 && n <= L2 + 4, "new tap on refresh");
    wait_lvl(1'b1, n);
    $display("test modes done");
    results();
  end
endmodule
`default_nettype wire
